// File: src/dtcu_timer.sv
// Dual timer/counter unit with shared control register and external interrupt flags.
// Assumes an 8-bit register port from the core, pins asynchronous to i_clk.
// Notes on behaviour
// R01 - Unit one overflow flag sets on wrap; cleared by software or on vectoring.
// R02 - Unit zero overflow flag sets on roll to zero; cleared by software or vectoring.
// R03 - Each unit counts only while its run bit is one.
// R04 - Ext irq one flag sets on chosen edge or level; clears by software or service.
// R05 - Ext irq zero flag sets on chosen edge or level; clears by software or service.
// R06 - Type bit zero means low level trigger, one means falling edge.
// R07 - Unit one gate bit set makes counting also need irq one pin high.
// R08 - Unit zero gate bit set makes counting also need irq zero pin high.
// R09 - Unit one counter select: zero counts ticks, one counts count pin edges.
// R10 - Unit zero counter select: zero counts ticks, one counts count pin edges.
// R11 - Unit one modes: 13-bit, 16-bit, 8-bit reload, or stopped.
// R12 - Unit zero modes: 13-bit, 16-bit, 8-bit reload, or split dual 8-bit.
// R13 - Reload mode loads low byte from high byte on every low byte overflow.
// R14 - Split: low byte under unit zero bits; high byte timer uses unit one bits.
// R15 - 13-bit count is high byte over low five bits of the low byte.
// R16 - 16-bit mode cascades both bytes; roll to zero sets the overflow flag.
// R17 - Setting the run bit leaves the count registers unchanged.
// R18 - Timer operation advances every 12 clocks, or every 6 in fast option.
// R19 - Count pin sampled each clock; high then low sample increments.
// R20 - Unit one in mode 3 holds its count as if stopped.
// R21 - Auto reload leaves the high reload byte unchanged.
// R22 - Software write to a count byte wins over a same-cycle increment.
`timescale 1ns/1ns
module dtcu_timer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Configuration
    input wire logic i_fast_mode,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic i_write,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // Vector acknowledges from the interrupt controller
    input wire logic i_ack_unit_zero,
    input wire logic i_ack_unit_one,
    input wire logic i_ack_ext_zero,
    input wire logic i_ack_ext_one,
    // Pins
    input wire logic i_ext_irq_zero_pin,
    input wire logic i_ext_irq_one_pin,
    input wire logic i_unit_zero_count_pin,
    input wire logic i_unit_one_count_pin,
    // Interrupt requests
    output logic o_unit_zero_overflow_flag,
    output logic o_unit_one_overflow_flag,
    output logic o_ext_irq_zero_flag,
    output logic o_ext_irq_one_flag
);
    typedef struct packed {
        logic [7:0] timer_control;
        logic [7:0] timer_mode;
        logic [7:0] unit_zero_count_low;
        logic [7:0] unit_one_count_low;
        logic [7:0] unit_zero_count_high;
        logic [7:0] unit_one_count_high;
        logic [3:0] sync_first;
        logic [3:0] sync_second;
        logic [3:0] sync_prev;
        logic [7:0] rdata;
    } dtcu_state_t;

    // Sync bit order: 3 irq one, 2 irq zero, 1 count one, 0 count zero
    dtcu_state_t state;
    dtcu_state_t next_state;
    dtcu_tick_if tick_link ();

    // Synchronisers restart at the idle-high pin level, so reset shows no false low or fall
    localparam dtcu_state_t STATE_AT_RESET = '{sync_first: 4'hF, sync_second: 4'hF,
        sync_prev: 4'hF, default: '0};

    dtcu_prescaler prescaler (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_fast_mode(i_fast_mode),
        .tick_port(tick_link)
    );

    // Count enable of one unit: run, gate and source selection
    function automatic logic unit_step(input logic [3:0] nib, input logic run,
                                       input logic gate_pin, input logic tick,
                                       input logic pin_fall);
        logic src;
        src = nib[dtcu_pkg::MODE_COUNTER_SELECT] ? pin_fall : tick;
        return run && (!nib[dtcu_pkg::MODE_GATE] || gate_pin) && src;
    endfunction : unit_step

    // Advance one counter pair; returns {overflow, high, low}
    function automatic logic [16:0] pair_step(input logic [1:0] mode,
                                              input logic [7:0] high,
                                              input logic [7:0] low);
        logic [16:0] res;
        logic [8:0] low_sum;
        logic [16:0] wide;
        logic [13:0] mid;
        res = {1'b0, high, low};
        low_sum = {1'b0, low} + 9'h001;
        wide = {1'b0, high, low} + 17'h00001;
        mid = {1'b0, high, low[dtcu_pkg::LOW_BITS_13BIT-1:0]} + 14'h0001;
        case (mode)
            dtcu_pkg::MODE_13BIT: begin
                res = {mid[13], mid[12:5], low[7:5], mid[4:0]};
            end
            dtcu_pkg::MODE_16BIT: begin
                res = wide;
            end
            dtcu_pkg::MODE_RELOAD: begin
                res = {low_sum[8], high, low_sum[8] ? high : low_sum[7:0]};
            end
            default: begin
                res = {low_sum[8], high, low_sum[7:0]};
            end
        endcase
        return res;
    endfunction : pair_step

    logic [3:0] mode_zero;
    logic [3:0] mode_one;
    logic [3:0] falls;
    logic [7:0] ctl;
    assign mode_zero = state.timer_mode[dtcu_pkg::MODE_UNIT_ZERO_LSB +: 4];
    assign mode_one = state.timer_mode[dtcu_pkg::MODE_UNIT_ONE_LSB +: 4];
    // R19 high then low sample
    assign falls = state.sync_prev & ~state.sync_second;
    assign ctl = state.timer_control;

    always_comb begin
        logic step_zero;
        logic step_one;
        logic step_split;
        logic split;
        logic [16:0] res_zero;
        logic [16:0] res_one;
        logic [8:0] split_sum;
        logic set_of0;
        logic set_of1;
        logic set_ext0;
        logic set_ext1;
        step_zero = 1'b0;
        step_one = 1'b0;
        step_split = 1'b0;
        split = 1'b0;
        res_zero = '0;
        res_one = '0;
        split_sum = '0;
        set_of0 = 1'b0;
        set_of1 = 1'b0;
        set_ext0 = 1'b0;
        set_ext1 = 1'b0;
        next_state = state;

        // Pin synchronisers; the first stage only feeds the second, and only the second stage and its delayed copy sync_prev are used
        next_state.sync_first = {i_ext_irq_one_pin, i_ext_irq_zero_pin,
                                 i_unit_one_count_pin, i_unit_zero_count_pin};
        next_state.sync_second = state.sync_first;
        next_state.sync_prev = state.sync_second;

        split = mode_zero[1:0] == dtcu_pkg::MODE_SPLIT;
        // R03 run gating; R08 gate on irq zero pin; R10 source select
        step_zero = unit_step(mode_zero, ctl[dtcu_pkg::CTL_UNIT_ZERO_RUN],
                              state.sync_second[2], tick_link.tick, falls[0]);
        // R07 gate on irq one pin; R09 source select
        step_one = unit_step(mode_one, ctl[dtcu_pkg::CTL_UNIT_ONE_RUN],
                             state.sync_second[3], tick_link.tick, falls[1]);
        // R20 mode 3 holds unit one
        if (mode_one[1:0] == dtcu_pkg::MODE_SPLIT) begin
            step_one = 1'b0;
        end
        // R14 high byte timer on unit one run bit
        step_split = split && ctl[dtcu_pkg::CTL_UNIT_ONE_RUN] && tick_link.tick;

        // R12 unit zero modes; R13 R15 R16 R21 pair arithmetic
        res_zero = pair_step(mode_zero[1:0], state.unit_zero_count_high,
                             state.unit_zero_count_low);
        if (step_zero) begin
            next_state.unit_zero_count_low = res_zero[7:0];
            next_state.unit_zero_count_high = res_zero[15:8];
            set_of0 = res_zero[16];
        end
        split_sum = {1'b0, state.unit_zero_count_high} + 9'h001;
        if (step_split) begin
            next_state.unit_zero_count_high = split_sum[7:0];
            set_of1 = split_sum[8];
        end
        // R11 unit one modes
        res_one = pair_step(mode_one[1:0], state.unit_one_count_high,
                            state.unit_one_count_low);
        if (step_one) begin
            next_state.unit_one_count_low = res_one[7:0];
            next_state.unit_one_count_high = res_one[15:8];
            // R14 overflow flag taken over in split mode
            set_of1 = split ? set_of1 : res_one[16];
        end

        // R06 level or falling edge
        set_ext0 = ctl[dtcu_pkg::CTL_EXT_ZERO_TYPE] ? falls[2] : !state.sync_second[2];
        set_ext1 = ctl[dtcu_pkg::CTL_EXT_ONE_TYPE] ? falls[3] : !state.sync_second[3];

        // R17 R22 software writes; run bit write touches no count
        if (i_write) begin
            case (i_addr)
                dtcu_pkg::ADDR_TIMER_CONTROL: next_state.timer_control = i_wdata;
                dtcu_pkg::ADDR_TIMER_MODE: next_state.timer_mode = i_wdata;
                dtcu_pkg::ADDR_UNIT_ZERO_COUNT_LOW: next_state.unit_zero_count_low = i_wdata;
                dtcu_pkg::ADDR_UNIT_ONE_COUNT_LOW: next_state.unit_one_count_low = i_wdata;
                dtcu_pkg::ADDR_UNIT_ZERO_COUNT_HIGH: next_state.unit_zero_count_high = i_wdata;
                dtcu_pkg::ADDR_UNIT_ONE_COUNT_HIGH: next_state.unit_one_count_high = i_wdata;
                default: begin
                end
            endcase
        end

        // R02 hardware clear on vectoring, set wins
        if (i_ack_unit_zero) begin
            next_state.timer_control[dtcu_pkg::CTL_UNIT_ZERO_OVERFLOW] = 1'b0;
        end
        if (set_of0) begin
            next_state.timer_control[dtcu_pkg::CTL_UNIT_ZERO_OVERFLOW] = 1'b1;
        end
        // R01 hardware clear on vectoring, set wins
        if (i_ack_unit_one) begin
            next_state.timer_control[dtcu_pkg::CTL_UNIT_ONE_OVERFLOW] = 1'b0;
        end
        if (set_of1) begin
            next_state.timer_control[dtcu_pkg::CTL_UNIT_ONE_OVERFLOW] = 1'b1;
        end
        // R05 ext zero flag
        if (i_ack_ext_zero) begin
            next_state.timer_control[dtcu_pkg::CTL_EXT_ZERO_FLAG] = 1'b0;
        end
        if (set_ext0) begin
            next_state.timer_control[dtcu_pkg::CTL_EXT_ZERO_FLAG] = 1'b1;
        end
        // R04 ext one flag
        if (i_ack_ext_one) begin
            next_state.timer_control[dtcu_pkg::CTL_EXT_ONE_FLAG] = 1'b0;
        end
        if (set_ext1) begin
            next_state.timer_control[dtcu_pkg::CTL_EXT_ONE_FLAG] = 1'b1;
        end

        // Read data registered; unmapped addresses read zero
        case (i_addr)
            dtcu_pkg::ADDR_TIMER_CONTROL: next_state.rdata = state.timer_control;
            dtcu_pkg::ADDR_TIMER_MODE: next_state.rdata = state.timer_mode;
            dtcu_pkg::ADDR_UNIT_ZERO_COUNT_LOW: next_state.rdata = state.unit_zero_count_low;
            dtcu_pkg::ADDR_UNIT_ONE_COUNT_LOW: next_state.rdata = state.unit_one_count_low;
            dtcu_pkg::ADDR_UNIT_ZERO_COUNT_HIGH: next_state.rdata = state.unit_zero_count_high;
            dtcu_pkg::ADDR_UNIT_ONE_COUNT_HIGH: next_state.rdata = state.unit_one_count_high;
            default: next_state.rdata = dtcu_pkg::RESET_VALUE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= STATE_AT_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
    assign o_unit_zero_overflow_flag = state.timer_control[dtcu_pkg::CTL_UNIT_ZERO_OVERFLOW];
    assign o_unit_one_overflow_flag = state.timer_control[dtcu_pkg::CTL_UNIT_ONE_OVERFLOW];
    assign o_ext_irq_zero_flag = state.timer_control[dtcu_pkg::CTL_EXT_ZERO_FLAG];
    assign o_ext_irq_one_flag = state.timer_control[dtcu_pkg::CTL_EXT_ONE_FLAG];
endmodule : dtcu_timer

// File: src/dtcu_pkg.sv
// Package for the dual timer/counter unit: register offsets, field positions, timing.
// Assumes an 8-bit special function register bus driven by the processor core.
package dtcu_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
    localparam logic [7:0] ADDR_UNIT_ZERO_COUNT_LOW = 8'h8A;
    localparam logic [7:0] ADDR_UNIT_ONE_COUNT_LOW = 8'h8B;
    localparam logic [7:0] ADDR_UNIT_ZERO_COUNT_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_UNIT_ONE_COUNT_HIGH = 8'h8D;
    // Reset values
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Control register field positions
    localparam int CTL_UNIT_ONE_OVERFLOW = 7;
    localparam int CTL_UNIT_ONE_RUN = 6;
    localparam int CTL_UNIT_ZERO_OVERFLOW = 5;
    localparam int CTL_UNIT_ZERO_RUN = 4;
    localparam int CTL_EXT_ONE_FLAG = 3;
    localparam int CTL_EXT_ONE_TYPE = 2;
    localparam int CTL_EXT_ZERO_FLAG = 1;
    localparam int CTL_EXT_ZERO_TYPE = 0;
    // Mode register nibble: gate, counter select, mode pair
    localparam int MODE_UNIT_ONE_LSB = 4;
    localparam int MODE_UNIT_ZERO_LSB = 0;
    localparam int MODE_GATE = 3;
    localparam int MODE_COUNTER_SELECT = 2;
    localparam int MODE_SELECT_HIGH = 1;
    localparam int MODE_SELECT_LOW = 0;
    // Operating modes
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam int LOW_BITS_13BIT = 5;
    // Timing: system clock ticks per count
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int TICKS_SLOW = 12;
    localparam int TICKS_FAST = 6;
    localparam int PRESCALE_WIDTH = 4;
endpackage : dtcu_pkg

// File: src/dtcu_tick_if.sv
// Interface carrying the prescaler tick from the prescaler to the core.
// Assumes both ends share i_clk.
`timescale 1ns/1ns
interface dtcu_tick_if;
    logic tick;
    modport source (output tick);
    modport sink (input tick);
endinterface : dtcu_tick_if

// File: src/dtcu_prescaler.sv
// Prescaler giving one tick every 12 or every 6 system clocks.
// Assumes the speed option is static configuration, synchronous to i_clk.
`timescale 1ns/1ns
module dtcu_prescaler (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Configuration
    input wire logic i_fast_mode,
    // Tick out
    dtcu_tick_if.source tick_port
);
    typedef struct packed {
        logic [dtcu_pkg::PRESCALE_WIDTH-1:0] count;
        logic tick;
    } dtcu_pre_state_t;

    localparam logic [dtcu_pkg::PRESCALE_WIDTH-1:0] LAST_SLOW =
        dtcu_pkg::PRESCALE_WIDTH'(dtcu_pkg::TICKS_SLOW - 1);
    localparam logic [dtcu_pkg::PRESCALE_WIDTH-1:0] LAST_FAST =
        dtcu_pkg::PRESCALE_WIDTH'(dtcu_pkg::TICKS_FAST - 1);

    dtcu_pre_state_t state;
    dtcu_pre_state_t next_state;

    // R18 tick every 12 or 6
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.count >= (i_fast_mode ? LAST_FAST : LAST_SLOW)) begin
            next_state.count = '0;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick_port.tick = state.tick;
endmodule : dtcu_prescaler

// File: tb/dtcu_timer_properties.sv
// Checker for the dual timer/counter unit, bound to its top module.
// Assumes counts advance at most once every 6 clocks and pins are 2-flop synced.
`timescale 1ns/1ns
module dtcu_timer_properties (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic i_write,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    // Acknowledges and pins
    input wire logic i_ack_unit_zero,
    input wire logic i_ack_unit_one,
    input wire logic i_ack_ext_zero,
    input wire logic i_ack_ext_one,
    input wire logic i_ext_irq_zero_pin,
    input wire logic i_ext_irq_one_pin,
    // Flags
    input wire logic o_unit_zero_overflow_flag,
    input wire logic o_unit_one_overflow_flag,
    input wire logic o_ext_irq_zero_flag,
    input wire logic o_ext_irq_one_flag
);
    logic run_zero;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Shadow of the software run bit; the flag outputs alone cannot show it
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            run_zero <= 1'b0;
        end else if (i_write && i_addr == dtcu_pkg::ADDR_TIMER_CONTROL) begin
            run_zero <= i_wdata[dtcu_pkg::CTL_UNIT_ZERO_RUN];
        end
    end
    sequence s_zero_high;
        (i_ext_irq_zero_pin && !i_write)[*5];
    endsequence
    sequence s_zero_low;
        (!i_ext_irq_zero_pin && !i_write && !i_ack_ext_zero)[*6];
    endsequence
    sequence s_one_high;
        (i_ext_irq_one_pin && !i_write)[*5];
    endsequence
    property p_reset_clear;
        disable iff (1'b0) i_reset |=> o_rdata == 8'h00 && !o_unit_zero_overflow_flag
            && !o_unit_one_overflow_flag && !o_ext_irq_zero_flag && !o_ext_irq_one_flag;
    endproperty
    property p_write_wins;
        i_write && i_addr == dtcu_pkg::ADDR_UNIT_ZERO_COUNT_LOW
            ##1 i_addr == dtcu_pkg::ADDR_UNIT_ZERO_COUNT_LOW |=> o_rdata == $past(i_wdata, 2);
    endproperty
    property p_ack_zero;
        i_ack_unit_zero |-> ##[1:2] !o_unit_zero_overflow_flag;
    endproperty
    property p_ack_one;
        i_ack_unit_one |-> ##[1:2] !o_unit_one_overflow_flag;
    endproperty
    property p_ext_zero_set;
        s_zero_high ##1 s_zero_low |-> o_ext_irq_zero_flag;
    endproperty
    property p_ext_one_set;
        s_one_high ##1 (!i_ext_irq_one_pin && !i_write && !i_ack_ext_one)[*6]
            |-> o_ext_irq_one_flag;
    endproperty
    property p_ext_zero_quiet;
        s_zero_high |-> !$rose(o_ext_irq_zero_flag);
    endproperty
    property p_run_zero;
        !run_zero && !i_write ##1 !i_write |-> !$rose(o_unit_zero_overflow_flag);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear in reset");
    a_write_wins: assert property (p_write_wins) else $error("count write lost");
    a_ack_zero: assert property (p_ack_zero) else $error("unit zero flag kept");
    a_ack_one: assert property (p_ack_one) else $error("unit one flag kept");
    a_ext_zero_set: assert property (p_ext_zero_set) else $error("ext zero missed");
    a_ext_one_set: assert property (p_ext_one_set) else $error("ext one missed");
    a_ext_zero_quiet: assert property (p_ext_zero_quiet) else $error("ext zero spurious");
    a_run_zero: assert property (p_run_zero) else $error("unit zero counted stopped");
endmodule : dtcu_timer_properties

bind dtcu_timer dtcu_timer_properties u_props (.i_clk, .i_reset, .i_addr, .i_write,
    .i_wdata, .o_rdata, .i_ack_unit_zero, .i_ack_unit_one, .i_ack_ext_zero, .i_ack_ext_one,
    .i_ext_irq_zero_pin, .i_ext_irq_one_pin, .o_unit_zero_overflow_flag,
    .o_unit_one_overflow_flag, .o_ext_irq_zero_flag, .o_ext_irq_one_flag);

// File: tb/dtcu_core_model.sv
// Processor core model: register writes, reads and vector acknowledges.
// Assumes the unit samples on the rising edge; this side moves on the falling one.
`timescale 1ns/1ns
module dtcu_core_model (
    // Clock
    input wire logic i_clk,
    // Register port
    output logic [7:0] o_addr,
    output logic o_write,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata,
    // Acknowledges: ext one, ext zero, unit one, unit zero
    output logic [3:0] o_ack
);
    initial begin
        o_addr = 8'h00;
        o_write = 1'b0;
        o_wdata = 8'h00;
        o_ack = 4'h0;
    end
    // Data inverts when the strobe drops, so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_write = 1'b1;
        @(negedge i_clk);
        o_write = 1'b0;
        o_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        @(negedge i_clk);
        d = i_rdata;
    endtask : rd
    task automatic ack(input logic [3:0] m);
        @(negedge i_clk);
        o_ack = m;
        @(negedge i_clk);
        o_ack = 4'h0;
    endtask : ack
endmodule : dtcu_core_model

// File: tb/dtcu_timer_bench.sv
// Self-checking bench for the dual timer/counter unit.
// Assumes the core model drives the register port; pins move on falling edges.
`timescale 1ns/1ns
module dtcu_timer_bench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic fast_mode = 1'b0;
    logic [1:0] irq_pin = 2'b11;
    logic [1:0] cnt_pin = 2'b11;
    logic [7:0] addr, wdata, rdata;
    logic write;
    logic [3:0] ack, flag;
    int mismatches = 0;
    int checked = 0;
    always #(dtcu_pkg::CLOCK_PERIOD_NS / 2) clk = ~clk;
    dtcu_core_model core (.i_clk(clk), .o_addr(addr), .o_write(write), .o_wdata(wdata),
        .i_rdata(rdata), .o_ack(ack));
    dtcu_timer dut (.i_clk(clk), .i_reset(reset), .i_fast_mode(fast_mode),
        .i_addr(addr), .i_write(write), .i_wdata(wdata), .o_rdata(rdata),
        .i_ack_unit_zero(ack[0]), .i_ack_unit_one(ack[1]),
        .i_ack_ext_zero(ack[2]), .i_ack_ext_one(ack[3]),
        .i_ext_irq_zero_pin(irq_pin[0]), .i_ext_irq_one_pin(irq_pin[1]),
        .i_unit_zero_count_pin(cnt_pin[0]), .i_unit_one_count_pin(cnt_pin[1]),
        .o_unit_zero_overflow_flag(flag[0]), .o_unit_one_overflow_flag(flag[1]),
        .o_ext_irq_zero_flag(flag[2]), .o_ext_irq_one_flag(flag[3]));
    task automatic conclude();
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] v;
        core.rd(a, v);
        chk(v & m, exp);
    endtask : rdchk
    task automatic wait_flag(input int i);
        int n;
        n = 0;
        while (flag[i] !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (flag[i] !== 1'b1) begin
            chk({7'h00, flag[i]}, 8'h01);
            conclude();
        end
    endtask : wait_flag
    task automatic do_reset(input logic f);
        @(negedge clk);
        reset = 1'b1;
        fast_mode = f;
        repeat (20) @(negedge clk);
        reset = 1'b0;
    endtask : do_reset
    // Run window of exactly n edges, so the tick count in it is fixed
    task automatic run_for(input logic [7:0] ctl, input int n);
        core.wr(8'h88, ctl);
        repeat (n - 2) @(negedge clk);
        core.wr(8'h88, 8'h00);
    endtask : run_for
    task automatic t_regs();
        for (int a = 8'h88; a <= 8'h8D; a++) begin
            rdchk(8'(a), 8'h00, 8'hFF);
        end
        for (int a = 8'h89; a <= 8'h8D; a++) begin
            core.wr(8'(a), 8'(a) ^ 8'h5A);
            rdchk(8'(a), 8'(a) ^ 8'h5A, 8'hFF);
            core.wr(8'(a), 8'h00);
        end
        core.wr(8'h90, 8'hFF);
        rdchk(8'h90, 8'h00, 8'hFF);
    endtask : t_regs
    // prescaled rate from a preset count
    task automatic t_rate(input logic f);
        int n;
        n = f ? 60 : 120;
        do_reset(f);
        core.wr(8'h89, 8'h01);
        core.wr(8'h8A, 8'hF0);
        run_for(8'h10, n);
        rdchk(8'h8A, 8'hF0 + 8'(n / (f ? dtcu_pkg::TICKS_FAST : dtcu_pkg::TICKS_SLOW)),
            8'hFF);
        repeat (60) @(negedge clk);
        rdchk(8'h8A, 8'hFA, 8'hFF);
    endtask : t_rate
    // modes 0 to 2 overflow on both units
    task automatic t_ovf();
        logic [7:0] hi;
        for (int u = 0; u < 2; u++) begin
            for (int m = 0; m < 3; m++) begin
                hi = (m == 2) ? 8'hA0 : 8'h00;
                core.wr(8'h89, 8'(m << (4 * u)));
                core.wr(8'h8A + 8'(u), 8'hFF);
                core.wr(8'h8C + 8'(u), (m == 2) ? 8'hA0 : 8'hFF);
                core.wr(8'h88, 8'h10 << (2 * u));
                wait_flag(u);
                core.wr(8'h88, (m == 1) ? (8'h20 << (2 * u)) : 8'h00);
                rdchk(8'h8A + 8'(u), hi, (m == 0) ? 8'h1F : 8'hFF);
                rdchk(8'h8C + 8'(u), hi, 8'hFF);
                chk({7'h00, flag[u]}, (m == 1) ? 8'h01 : 8'h00);
                if (m == 1) begin
                    core.ack(4'(1 << u));
                end
                chk({7'h00, flag[u]}, 8'h00);
            end
        end
    endtask : t_ovf
    // split mode and the stopped unit one
    task automatic t_split();
        core.wr(8'h89, 8'h03);
        core.wr(8'h8A, 8'h00);
        core.wr(8'h8C, 8'hFF);
        core.wr(8'h88, 8'h40);
        wait_flag(1);
        core.wr(8'h88, 8'h00);
        rdchk(8'h8C, 8'h00, 8'hFF);
        rdchk(8'h8A, 8'h00, 8'hFF);
        chk({7'h00, flag[0]}, 8'h00);
        core.wr(8'h89, 8'h30);
        core.wr(8'h8B, 8'h05);
        run_for(8'h40, 60);
        rdchk(8'h8B, 8'h05, 8'hFF);
    endtask : t_split
    // falling edges on the count pins
    task automatic t_counter();
        for (int u = 0; u < 2; u++) begin
            core.wr(8'h89, 8'(5 << (4 * u)));
            core.wr(8'h8A + 8'(u), 8'h00);
            core.wr(8'h88, 8'h10 << (2 * u));
            repeat (3) begin
                cnt_pin[u] = 1'b0;
                repeat (6) @(negedge clk);
                cnt_pin[u] = 1'b1;
                repeat (6) @(negedge clk);
            end
            core.wr(8'h88, 8'h00);
            rdchk(8'h8A + 8'(u), 8'h03, 8'hFF);
            // Fall is counted on the third edge after the pin drops, with the write
            core.wr(8'h88, 8'h10 << (2 * u));
            cnt_pin[u] = 1'b0;
            @(negedge clk);
            core.wr(8'h8A + 8'(u), 8'h33);
            core.wr(8'h88, 8'h00);
            cnt_pin[u] = 1'b1;
            rdchk(8'h8A + 8'(u), 8'h33, 8'hFF);
        end
    endtask : t_counter
    // gate holds the count while the pin is low
    task automatic t_gate();
        for (int u = 0; u < 2; u++) begin
            core.wr(8'h89, 8'(9 << (4 * u)));
            core.wr(8'h8A + 8'(u), 8'h00);
            irq_pin[u] = 1'b0;
            run_for(8'h10 << (2 * u), 120);
            rdchk(8'h8A + 8'(u), 8'h00, 8'hFF);
            irq_pin[u] = 1'b1;
            run_for(8'h10 << (2 * u), 120);
            rdchk(8'h8A + 8'(u), 8'h0A, 8'hFF);
        end
    endtask : t_gate
    task automatic t_ext();
        for (int u = 0; u < 2; u++) begin
            for (int t = 0; t < 2; t++) begin
                core.wr(8'h88, 8'(t << (2 * u)));
                repeat (8) @(negedge clk);
                irq_pin[u] = 1'b0;
                repeat (8) @(negedge clk);
                chk({7'h00, flag[2 + u]}, 8'h01);
                core.ack(4'(4 << u));
                repeat (4) @(negedge clk);
                chk({7'h00, flag[2 + u]}, 8'(1 - t));
                irq_pin[u] = 1'b1;
                repeat (4) @(negedge clk);
                core.wr(8'h88, 8'h00);
                chk({7'h00, flag[2 + u]}, 8'h00);
            end
        end
    endtask : t_ext
    initial begin
        do_reset(1'b0);
        t_regs();
        t_rate(1'b0);
        t_ovf();
        t_split();
        t_counter();
        t_gate();
        t_ext();
        t_rate(1'b1);
        conclude();
    end
endmodule : dtcu_timer_bench
